// file: src/sarfmt_consts.svh
/*
 * Named constants of the converter result and window block: register
 * addresses, reset values, reference select codes and data widths.
 * Assumes nothing; definitions only, included by the package and the top.
 */
`ifndef SARFMT_CONSTS_SVH
`define SARFMT_CONSTS_SVH

`define SARFMT_ADDR_RESULT_LOW 8'hbd
`define SARFMT_ADDR_RESULT_HIGH 8'hbe
`define SARFMT_RESULT_RESET 8'h00
`define SARFMT_READ_UNMAPPED 8'h00
`define SARFMT_REF_EXTERNAL 2'b00
`define SARFMT_REF_SUPPLY 2'b01
`define SARFMT_REF_DIGITAL 2'b10
`define SARFMT_REF_HIGH_SPEED 2'b11
`define SARFMT_CODE_BITS 10
`define SARFMT_BYTE_BITS 8

`endif

// file: src/sarfmt_pkg.sv
/*
 * Types shared by the converter result and window block.
 * Assumes sarfmt_consts.svh is on the include path.
 */
`include "sarfmt_consts.svh"

package sarfmt_pkg;

    typedef enum logic [1:0] {SAR_OFF, SAR_IDLE, SAR_BUSY} sarfmt_state_type;

    typedef struct packed {
        sarfmt_state_type state;
        logic [7:0] low;
        logic [7:0] high;
        logic flag;
        logic [7:0] rdata;
        logic gain;
        logic [1:0] refsel;
        logic analog_ground_pin;
        logic temp;
        logic hs_ref;
    } sarfmt_regs_type;

endpackage

// file: src/sarfmt_justify.sv
/*
 * Places a raw conversion code into the high and low result bytes.
 * Assumes the code arrives right-aligned; an 8-bit code sits in the low bits.
 */
`timescale 1ns/1ps
`default_nettype none

module sarfmt_justify
    import sarfmt_pkg::*;
#(
    parameter int CODE_WIDTH = `SARFMT_CODE_BITS,
    parameter int BYTE_WIDTH = `SARFMT_BYTE_BITS
)
(
    // Raw code and format select
    input wire logic [CODE_WIDTH-1:0] code,
    input wire logic left_justify,
    input wire logic eight_bit,
    // Formatted bytes
    output logic [BYTE_WIDTH-1:0] high_byte,
    output logic [BYTE_WIDTH-1:0] low_byte
);
    localparam int PAD = 2 * BYTE_WIDTH - CODE_WIDTH;

    always_comb
    begin
        if (eight_bit)
        begin
            high_byte = code[BYTE_WIDTH-1:0];
            low_byte = '0;
        end
        else if (left_justify)
        begin
            high_byte = code[CODE_WIDTH-1 -: BYTE_WIDTH];
            low_byte = {code[CODE_WIDTH-BYTE_WIDTH-1:0], {PAD{1'b0}}};
        end
        else
        begin
            high_byte = {{PAD{1'b0}}, code[CODE_WIDTH-1:BYTE_WIDTH]};
            low_byte = code[BYTE_WIDTH-1:0];
        end
    end
endmodule // sarfmt_justify

`default_nettype wire

// file: src/sarfmt_window.sv
/*
 * Window comparison of a formatted result word against two limits.
 * Assumes limits are given in the same justified format as the result.
 */
`timescale 1ns/1ps
`default_nettype none

module sarfmt_window
    import sarfmt_pkg::*;
#(
    parameter int WORD_WIDTH = 2 * `SARFMT_BYTE_BITS
)
(
    // Operands
    input wire logic [WORD_WIDTH-1:0] result,
    input wire logic [WORD_WIDTH-1:0] greater_limit,
    input wire logic [WORD_WIDTH-1:0] less_limit,
    // Comparison outcome
    output logic hit
);
    // Equal limits fall into the outside case, so only values off the limit hit.
    always_comb
    begin
        if (less_limit > greater_limit)
            hit = (result > greater_limit) && (result < less_limit);
        else
            hit = (result < less_limit) || (result > greater_limit);
    end
endmodule // sarfmt_window

`default_nettype wire

// file: src/sarfmt_top.sv
/*
 * Digital control and result handling of a 10-bit successive-approximation
 * converter: power sequencing, result justification, window detection and
 * the analog option controls. Assumes a synchronous special function
 * register port, and an analog core that reports each finished conversion
 * with a one-cycle done pulse carrying its code.
 */
`timescale 1ns/1ps
`default_nettype none
`include "sarfmt_consts.svh"

module sarfmt_top
    import sarfmt_pkg::*;
#(
    parameter int CODE_WIDTH = `SARFMT_CODE_BITS
)
(
    // Clock and reset
    input wire logic clock,
    input wire logic reset,
    // Special function register port
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_write,
    input wire logic sfr_read,
    input wire logic [7:0] sfr_wdata,
    output logic [7:0] sfr_rdata,
    // Control bits
    input wire logic converter_enable,
    input wire logic left_justify_select,
    input wire logic eight_bit_mode,
    input wire logic half_gain_select,
    input wire logic [1:0] reference_select,
    input wire logic analog_ground_select,
    input wire logic temp_sensor_enable,
    input wire logic window_flag_clear,
    // Window limits
    input wire logic [7:0] greater_limit_high,
    input wire logic [7:0] greater_limit_low,
    input wire logic [7:0] less_limit_high,
    input wire logic [7:0] less_limit_low,
    // Analog core
    input wire logic conv_start,
    input wire logic conv_done,
    input wire logic [CODE_WIDTH-1:0] conv_code,
    output logic sar_start_pulse,
    output logic sar_powered,
    output logic gain_half_on,
    output logic [1:0] reference_mux,
    output logic high_speed_ref_on,
    output logic analog_ground_pin_pin_ground,
    output logic temp_sensor_on,
    // Status
    output logic window_compare_flag,
    output logic converter_busy
);
    localparam int BYTE_W = `SARFMT_BYTE_BITS;
    localparam int PAD_W = 2 * BYTE_W - CODE_WIDTH;
    localparam int TOP_W = CODE_WIDTH - BYTE_W;
    localparam sarfmt_regs_type REGS_RESET = '{
        state: SAR_OFF,
        low: `SARFMT_RESULT_RESET,
        high: `SARFMT_RESULT_RESET,
        flag: 1'b0,
        rdata: `SARFMT_READ_UNMAPPED,
        gain: 1'b0,
        refsel: `SARFMT_REF_EXTERNAL,
        analog_ground_pin: 1'b0,
        temp: 1'b0,
        hs_ref: 1'b0
    };

    sarfmt_regs_type regs;
    sarfmt_regs_type next_regs;
    logic [BYTE_W-1:0] fmt_high;
    logic [BYTE_W-1:0] fmt_low;
    logic [2*BYTE_W-1:0] fmt_word;
    logic [2*BYTE_W-1:0] greater_word;
    logic [2*BYTE_W-1:0] less_word;
    logic win_hit;
    logic accept;

    sarfmt_justify #(
        .CODE_WIDTH(CODE_WIDTH),
        .BYTE_WIDTH(BYTE_W)
    ) u_justify (
        .code(conv_code),
        .left_justify(left_justify_select),
        .eight_bit(eight_bit_mode),
        .high_byte(fmt_high),
        .low_byte(fmt_low)
    );

    // Limits are taken as typed, so software writes them in the active format.
    assign fmt_word = {fmt_high, fmt_low};
    assign greater_word = {greater_limit_high, greater_limit_low};
    assign less_word = {less_limit_high, less_limit_low};

    sarfmt_window #(
        .WORD_WIDTH(2 * BYTE_W)
    ) u_window (
        .result(fmt_word),
        .greater_limit(greater_word),
        .less_limit(less_word),
        .hit(win_hit)
    );

    // A done pulse counts only for a running conversion of an enabled converter.
    assign accept = (regs.state == SAR_BUSY) && conv_done && converter_enable;
    assign sar_start_pulse = (regs.state == SAR_IDLE) && conv_start && converter_enable;

    function automatic logic [7:0] read_mux(input logic [7:0] addr,
                                            input sarfmt_regs_type r);
        case (addr)
            `SARFMT_ADDR_RESULT_LOW: read_mux = r.low;
            `SARFMT_ADDR_RESULT_HIGH: read_mux = r.high;
            default: read_mux = `SARFMT_READ_UNMAPPED;
        endcase
    endfunction

    always_comb
    begin
        next_regs = regs;
        case (regs.state)
            SAR_OFF:
            begin
                next_regs.state = SAR_IDLE;
            end
            SAR_IDLE:
            begin
                if (conv_start)
                    next_regs.state = SAR_BUSY;
            end
            SAR_BUSY:
            begin
                if (conv_done)
                    next_regs.state = SAR_IDLE;
            end
            default:
            begin
                next_regs.state = SAR_OFF;
            end
        endcase
        // Dropping the enable abandons any conversion in flight.
        if (!converter_enable)
            next_regs.state = SAR_OFF;

        if (sfr_read)
            next_regs.rdata = read_mux(sfr_addr, regs);
        if (sfr_write && sfr_addr == `SARFMT_ADDR_RESULT_LOW)
            next_regs.low = sfr_wdata;
        if (sfr_write && sfr_addr == `SARFMT_ADDR_RESULT_HIGH)
            next_regs.high = sfr_wdata;
        // A finishing conversion overrides a software write in the same cycle.
        if (accept)
        begin
            next_regs.low = fmt_low;
            next_regs.high = fmt_high;
        end

        if (window_flag_clear)
            next_regs.flag = 1'b0;
        if (accept && win_hit)
            next_regs.flag = 1'b1;

        next_regs.gain = half_gain_select;
        next_regs.refsel = reference_select;
        next_regs.analog_ground_pin = analog_ground_select;
        next_regs.temp = temp_sensor_enable;
        next_regs.hs_ref = (next_regs.state == SAR_BUSY)
            && (reference_select == `SARFMT_REF_HIGH_SPEED);
    end

    always_ff @(posedge clock)
    begin
        if (reset)
            regs <= REGS_RESET;
        else
            regs <= next_regs;
    end

    assign sfr_rdata = regs.rdata;
    assign sar_powered = (regs.state != SAR_OFF);
    assign converter_busy = (regs.state == SAR_BUSY);
    assign gain_half_on = regs.gain;
    assign reference_mux = regs.refsel;
    assign high_speed_ref_on = regs.hs_ref;
    assign analog_ground_pin_pin_ground = regs.analog_ground_pin;
    assign temp_sensor_on = regs.temp;
    assign window_compare_flag = regs.flag;

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (reset);

    sequence s_accept_right;
        accept && !eight_bit_mode && !left_justify_select;
    endsequence

    sequence s_accept_left;
        accept && !eight_bit_mode && left_justify_select;
    endsequence

    sequence s_accept_eight;
        accept && eight_bit_mode;
    endsequence

    sequence s_inside_hit;
        accept && (less_word > greater_word)
            && (fmt_word > greater_word) && (fmt_word < less_word);
    endsequence

    sequence s_outside_hit;
        accept && (less_word <= greater_word)
            && ((fmt_word < less_word) || (fmt_word > greater_word));
    endsequence

    a_disable_shutdown:
        assert property (!converter_enable |=> !sar_powered && !high_speed_ref_on)
        else $error("converter still powered after enable dropped");

    a_off_ignores_done:
        assert property (!converter_enable && !sfr_write |=> $stable(regs.low))
        else $error("result changed while converter disabled");

    a_right_high:
        assert property (s_accept_right |=> regs.high ==
            {{PAD_W{1'b0}}, $past(conv_code[CODE_WIDTH-1:BYTE_W])})
        else $error("right justified high byte wrong");

    a_left_high:
        assert property (s_accept_left |=>
            regs.high == $past(conv_code[CODE_WIDTH-1:TOP_W]))
        else $error("left justified high byte wrong");

    a_right_low:
        assert property (s_accept_right |=> regs.low == $past(conv_code[BYTE_W-1:0]))
        else $error("right justified low byte wrong");

    a_left_low:
        assert property (s_accept_left |=>
            regs.low == {$past(conv_code[TOP_W-1:0]), {PAD_W{1'b0}}})
        else $error("left justified low byte wrong");

    a_eight_high:
        assert property (s_accept_eight |=> regs.high == $past(conv_code[BYTE_W-1:0]))
        else $error("eight bit word not in high byte");

    a_eight_low:
        assert property (s_accept_eight ##1 !sfr_write[*2] |-> regs.low == '0)
        else $error("eight bit low byte not zero");

    a_unsigned_word:
        assert property (s_accept_right |=>
            {regs.high[TOP_W-1:0], regs.low} == $past(conv_code))
        else $error("right justified word differs from code");

    a_inside_flag:
        assert property (s_inside_hit |=> window_compare_flag)
        else $error("inside window hit not flagged");

    a_outside_flag:
        assert property (s_outside_hit |=> window_compare_flag)
        else $error("outside window hit not flagged");

    a_gain_follow:
        assert property (##1 gain_half_on == $past(half_gain_select))
        else $error("gain select not applied");

    a_ref_follow:
        assert property (##1 reference_mux == $past(reference_select))
        else $error("reference select not applied");

    a_hs_ref_need:
        assert property (high_speed_ref_on |->
            converter_busy && reference_mux == `SARFMT_REF_HIGH_SPEED)
        else $error("high speed reference on without need");

    a_analog_ground_pin_follow:
        assert property (##1 analog_ground_pin_pin_ground == $past(analog_ground_select))
        else $error("ground select not applied");

    a_flag_cause:
        assert property ($rose(window_compare_flag) |-> $past(accept))
        else $error("window flag set outside conversion end");

    a_flag_sticky:
        assert property (window_compare_flag && !window_flag_clear |=> window_compare_flag)
        else $error("window flag dropped without clear");

    a_set_beats_clear:
        assert property (accept && win_hit && window_flag_clear |=> window_compare_flag)
        else $error("clear beat a simultaneous set");

    a_start_busy:
        assert property (sar_start_pulse |=> converter_busy)
        else $error("accepted start did not raise busy");

    a_abort_busy:
        assert property (converter_busy && !converter_enable |=> !converter_busy)
        else $error("conversion kept running after enable dropped");

    a_done_idle:
        assert property (accept |=> !converter_busy)
        else $error("busy stayed high after conversion end");

    a_read_high:
        assert property (sfr_read && sfr_addr == `SARFMT_ADDR_RESULT_HIGH
            |=> sfr_rdata == $past(regs.high))
        else $error("high result byte read wrong");

    a_read_low:
        assert property (sfr_read && sfr_addr == `SARFMT_ADDR_RESULT_LOW
            |=> sfr_rdata == $past(regs.low))
        else $error("low result byte read wrong");

    a_flag_clear:
        assert property (window_compare_flag && window_flag_clear && !(accept && win_hit)
            |=> !window_compare_flag)
        else $error("window flag not cleared by software");

    a_flag_no_hit:
        assert property (!window_compare_flag && !(accept && win_hit)
            |=> !window_compare_flag)
        else $error("window flag set without a hit");

endmodule // sarfmt_top

`default_nettype wire

// file: sim/sarfmt_tb.sv
/*
 * Self-checking testbench of the converter result and window block: register
 * reset values and access, result justification in all modes, the window
 * detector in both window shapes and formats, shutdown and the option outputs.
 * Assumes sarfmt_top with its default code width and a 200 MHz clock.
 */
`timescale 1ns/1ps
`default_nettype none
`include "sarfmt_consts.svh"

module testbench;
    import sarfmt_pkg::*;

    logic clock = 1'b0;
    logic reset = 1'b1;
    logic [7:0] sfr_addr = 8'h00;
    logic sfr_write = 1'b0;
    logic sfr_read = 1'b0;
    logic [7:0] sfr_wdata = 8'h00;
    logic [7:0] sfr_rdata;
    logic converter_enable = 1'b1;
    logic left_justify_select = 1'b0;
    logic eight_bit_mode = 1'b0;
    logic half_gain_select = 1'b0;
    logic [1:0] reference_select = 2'b00;
    logic analog_ground_select = 1'b0;
    logic temp_sensor_enable = 1'b0;
    logic window_flag_clear = 1'b0;
    logic [7:0] greater_limit_high = 8'h00;
    logic [7:0] greater_limit_low = 8'h00;
    logic [7:0] less_limit_high = 8'h00;
    logic [7:0] less_limit_low = 8'h00;
    logic conv_start = 1'b0;
    logic conv_done = 1'b0;
    logic [9:0] conv_code = 10'h000;
    logic sar_start_pulse, sar_powered, gain_half_on, high_speed_ref_on;
    logic analog_ground_pin_pin_ground, temp_sensor_on, window_compare_flag, converter_busy;
    logic [1:0] reference_mux;
    int num_errors = 0;
    int comparisons = 0;

    always #2.5 clock = ~clock;

    sarfmt_top sarfmt_top_i (.clock, .reset, .sfr_addr, .sfr_write, .sfr_read, .sfr_wdata,
        .sfr_rdata, .converter_enable, .left_justify_select, .eight_bit_mode,
        .half_gain_select, .reference_select, .analog_ground_select, .temp_sensor_enable,
        .window_flag_clear, .greater_limit_high, .greater_limit_low, .less_limit_high,
        .less_limit_low, .conv_start, .conv_done, .conv_code, .sar_start_pulse,
        .sar_powered, .gain_half_on, .reference_mux, .high_speed_ref_on, .analog_ground_pin_pin_ground,
        .temp_sensor_on, .window_compare_flag, .converter_busy);

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic close_out();
        $display("errors %0d comparisons %0d", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic rd(input logic [7:0] addr, output logic [7:0] data);
        @(posedge clock);
        sfr_read <= 1'b1;
        sfr_addr <= addr;
        @(posedge clock);
        sfr_read <= 1'b0;
        #1;
        data = sfr_rdata;
    endtask

    task automatic wr(input logic [7:0] addr, input logic [7:0] data);
        @(posedge clock);
        sfr_write <= 1'b1;
        sfr_addr <= addr;
        sfr_wdata <= data;
        @(posedge clock);
        sfr_write <= 1'b0;
    endtask

    // One whole conversion; the busy window and the reference power are looked at inside.
    task automatic conv(input logic [9:0] code);
        @(posedge clock);
        conv_start <= 1'b1;
        #1;
        check(sar_start_pulse, 1'b1);
        @(posedge clock);
        conv_start <= 1'b0;
        #1;
        check(converter_busy, 1'b1);
        check(high_speed_ref_on, reference_select == 2'b11);
        @(posedge clock);
        conv_done <= 1'b1;
        conv_code <= code;
        @(posedge clock);
        conv_done <= 1'b0;
        #1;
        check(converter_busy, 1'b0);
        check(high_speed_ref_on, 1'b0);
    endtask

    task automatic fmt(input logic lj, input logic eb, input logic [9:0] code);
        logic [7:0] hi;
        logic [7:0] lo;
        @(posedge clock);
        left_justify_select <= lj;
        eight_bit_mode <= eb;
        conv(code);
        rd(`SARFMT_ADDR_RESULT_HIGH, hi);
        rd(`SARFMT_ADDR_RESULT_LOW, lo);
        check(hi, eb ? code[7:0] : lj ? code[9:2] : {6'h00, code[9:8]});
        check(lo, eb ? 8'h00 : lj ? {code[1:0], 6'h00} : code[7:0]);
    endtask

    task automatic win(input logic lj, input logic [15:0] gt, input logic [15:0] lt,
                       input logic [9:0] code, input logic exp);
        @(posedge clock);
        left_justify_select <= lj;
        eight_bit_mode <= 1'b0;
        {greater_limit_high, greater_limit_low} <= gt;
        {less_limit_high, less_limit_low} <= lt;
        window_flag_clear <= 1'b1;
        @(posedge clock);
        window_flag_clear <= 1'b0;
        conv(code);
        check(window_compare_flag, exp);
    endtask

    initial
    begin
        repeat (5000) @(posedge clock);
        num_errors++;
        $display("unexpected timeout at %0t", $time);
        close_out();
    end

    initial
    begin
        logic [7:0] data;
        repeat (4) @(posedge clock);
        reset <= 1'b0;
        repeat (2) @(posedge clock);
        rd(`SARFMT_ADDR_RESULT_HIGH, data);
        check(data, 8'h00);
        rd(`SARFMT_ADDR_RESULT_LOW, data);
        check(data, 8'h00);
        rd(8'hc0, data);
        check(data, 8'h00);
        wr(`SARFMT_ADDR_RESULT_HIGH, 8'h5a);
        wr(8'hbf, 8'hff);
        rd(`SARFMT_ADDR_RESULT_HIGH, data);
        check(data, 8'h5a);
        $display("test registers done");

        for (int m = 0; m < 4; m++)
        begin
            fmt(m[0], m[1], 10'h3a5);
            fmt(m[0], m[1], 10'h3ff);
            fmt(m[0], m[1], 10'h001);
        end
        $display("test justification done");

        // Inside window with right and left justified limits, boundaries excluded.
        win(1'b0, 16'h0040, 16'h0080, 10'h041, 1'b1);
        win(1'b0, 16'h0040, 16'h0080, 10'h080, 1'b0);
        win(1'b0, 16'h0040, 16'h0080, 10'h040, 1'b0);
        win(1'b1, 16'h1000, 16'h2000, 10'h041, 1'b1);
        win(1'b1, 16'h1000, 16'h2000, 10'h081, 1'b0);
        // Outside window: the less-than limit sits below the greater-than limit.
        win(1'b0, 16'h0080, 16'h0040, 10'h03f, 1'b1);
        win(1'b0, 16'h0080, 16'h0040, 10'h081, 1'b1);
        win(1'b0, 16'h0080, 16'h0040, 10'h060, 1'b0);
        win(1'b0, 16'h0080, 16'h0040, 10'h040, 1'b0);
        win(1'b1, 16'h2000, 16'h1000, 10'h3ff, 1'b1);
        conv(10'h060);
        check(window_compare_flag, 1'b1);
        $display("test window done");

        for (int i = 0; i < 4; i++)
        begin
            @(posedge clock);
            reference_select <= i[1:0];
            half_gain_select <= i[0];
            analog_ground_select <= i[1];
            temp_sensor_enable <= ~i[0];
            @(posedge clock);
            #1;
            check(reference_mux, i[1:0]);
            check(gain_half_on, i[0]);
            check(analog_ground_pin_pin_ground, i[1]);
            check(temp_sensor_on, !i[0]);
            conv(10'h155);
        end
        $display("test options done");

        @(posedge clock);
        converter_enable <= 1'b0;
        repeat (2) @(posedge clock);
        conv_start <= 1'b1;
        #1;
        check(sar_powered, 1'b0);
        check(sar_start_pulse, 1'b0);
        // A done pulse while shut down must leave the last result in place.
        @(posedge clock);
        conv_start <= 1'b0;
        conv_done <= 1'b1;
        conv_code <= 10'h3ff;
        #1;
        check(converter_busy, 1'b0);
        @(posedge clock);
        conv_done <= 1'b0;
        converter_enable <= 1'b1;
        repeat (2) @(posedge clock);
        #1;
        check(sar_powered, 1'b1);
        rd(`SARFMT_ADDR_RESULT_HIGH, data);
        check(data, 8'h55);
        fmt(1'b0, 1'b0, 10'h2c3);
        $display("test shutdown done");
        close_out();
    end
endmodule // testbench
`default_nettype wire
